// >>> design/gyro_params.svh
// Purpose: constants for the gyro rate and register readout block
// Assumes: 100 MHz ref_clk, SPI mode 3 (clock idles high)
// Notes: command and response layouts below are local choices
// What this block does
// - data latched at chip select, reported next exchange
// - commands answered in the very next exchange
// - after test clears, flagged requests return error
// - rate is 16 bits in 32-bit frame, MSB first
// - two's complement, 80 counts per degree per second
// - rate saturates at 0x7fff and 0x8000
// - 300 deg/s reads 0x5dc0, zero reads 0x0000
// - any register read returns two consecutive bytes
// - even byte high, following byte low
// - register data shifted out MSB first
// - rate pair holds filtered compensated rate
// - sensor data command returns same rate
// - byte registers at 0x00 through 0x11
// - faults generated within 50 ms of test request
// - status 10 while test request is set
// - faults decay 50 ms after test clears
`ifndef GYRO_PARAMS_SVH
`define GYRO_PARAMS_SVH

`define REF_CLK_KHZ     100000
`define FAULT_GEN_MS    50
`define FAULT_DECAY_MS  50
`define RATE_DIV_DEF    32

`define ADDR_RATE_HI    8'h00
`define ADDR_RATE_LO    8'h01
`define ADDR_TEMP_HI    8'h02
`define ADDR_TEMP_LO    8'h03
`define ADDR_LOST_HI    8'h04
`define ADDR_LOST_LO    8'h05
`define ADDR_HIST_HI    8'h06
`define ADDR_HIST_LO    8'h07
`define ADDR_QUAD_HI    8'h08
`define ADDR_QUAD_LO    8'h09
`define ADDR_FAULT_HI   8'h0a
`define ADDR_FAULT_LO   8'h0b
`define ADDR_PART_HI    8'h0c
`define ADDR_PART_LO    8'h0d
`define ADDR_SER3       8'h0e
`define ADDR_SER2       8'h0f
`define ADDR_SER1       8'h10
`define ADDR_SER0       8'h11

`define CMD_OP_MSB      31
`define CMD_OP_LSB      30
`define CMD_ADDR_MSB    24
`define CMD_ADDR_LSB    17
`define CMD_WDATA_MSB   16
`define CMD_WDATA_LSB   1
`define CMD_CHK_BIT     1
`define OP_SENSOR       2'h0
`define OP_WRITE        2'h1
`define OP_READ         2'h2

`define ST_ERROR        2'h0
`define ST_VALID        2'h1
`define ST_SELFTEST     2'h2

`define FLT_FAIL        11
`define FLT_CST         2
`define FLT_CHK         1
`define RATE_MAX        16'h7fff
`define RATE_MIN        16'h8000

`endif

// >>> design/gyro_pkg.sv
// Purpose: types for the gyro readout block
// Assumes: nothing
// Notes: constants live in gyro_params.svh
package gyro_pkg;
   typedef enum logic [1:0] {FT_IDLE, FT_GEN, FT_ACTIVE, FT_DECAY} ft_state_e;
   typedef enum logic [1:0] {CMD_SENSOR, CMD_READ, CMD_WRITE, CMD_NONE} cmd_kind_e;
endpackage

// >>> design/gyro_spi_rate_register_readout.sv
// Purpose: spi command/response readout of a digital rate sensor
// Assumes: spi mode 3, 32-bit frames, cs_n high at least 100 ns
// Notes: the spi side runs on spi_clk; words cross quasi-statically
`timescale 1ns/1ps
`include "gyro_params.svh"

module gyro_spi_rate_register_readout
   import gyro_pkg::*;
#(
   parameter int          RATE_IN_W  = 20,
   parameter int          RATE_DIV   = `RATE_DIV_DEF,
   parameter int          FILT_SHIFT = 3,
   parameter int          CNT_W      = 23,
   parameter int          GEN_CYC    = `FAULT_GEN_MS * `REF_CLK_KHZ,
   parameter int          DECAY_CYC  = `FAULT_DECAY_MS * `REF_CLK_KHZ,
   // arbitrary identity values
   parameter logic [15:0] PART_ID    = 16'h0a5a,
   parameter logic [31:0] SERIAL_NUM = 32'h0000_0001
)(
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   input  wire logic                        spi_clk,
   input  wire logic                        cs_n,
   input  wire logic                        mosi,
   input  wire logic signed [RATE_IN_W-1:0] rate_in,
   input  wire logic        [9:0]           temp_in,
   input  wire logic        [15:0]          lo_st_in,
   input  wire logic        [15:0]          hi_st_in,
   input  wire logic        [15:0]          quad_in,
   input  wire logic        [9:0]           fault_src,
   output logic                             miso,
   output logic                             miso_oe,
   output logic                             fault_induce
);

   localparam int FW = RATE_IN_W + 2;

   function automatic logic [15:0] sat16(input logic signed [FW-1:0] v);
      if (v > $signed({{(FW-16){1'b0}}, `RATE_MAX}))
         return `RATE_MAX;
      if (v < $signed({{(FW-16){1'b1}}, `RATE_MIN}))
         return `RATE_MIN;
      return v[15:0];
   endfunction

   function automatic logic [7:0] reg_byte(input logic [7:0]  a,
                                           input logic [95:0] v);
      logic [7:0] b;
      b = 8'h00;
      unique case (a)
         `ADDR_RATE_HI:  b = v[95:88];
         `ADDR_RATE_LO:  b = v[87:80];
         `ADDR_TEMP_HI:  b = v[79:72];
         `ADDR_TEMP_LO:  b = v[71:64];
         `ADDR_LOST_HI:  b = v[63:56];
         `ADDR_LOST_LO:  b = v[55:48];
         `ADDR_HIST_HI:  b = v[47:40];
         `ADDR_HIST_LO:  b = v[39:32];
         `ADDR_QUAD_HI:  b = v[31:24];
         `ADDR_QUAD_LO:  b = v[23:16];
         `ADDR_FAULT_HI: b = v[15:8];
         `ADDR_FAULT_LO: b = v[7:0];
         `ADDR_PART_HI:  b = PART_ID[15:8];
         `ADDR_PART_LO:  b = PART_ID[7:0];
         `ADDR_SER3:     b = SERIAL_NUM[31:24];
         `ADDR_SER2:     b = SERIAL_NUM[23:16];
         `ADDR_SER1:     b = SERIAL_NUM[15:8];
         `ADDR_SER0:     b = SERIAL_NUM[7:0];
         default:        b = 8'h00;
      endcase
      return b;
   endfunction

   function automatic cmd_kind_e cmd_kind(input logic [31:0] w);
      unique case (w[`CMD_OP_MSB:`CMD_OP_LSB])
         `OP_SENSOR: return CMD_SENSOR;
         `OP_READ:   return CMD_READ;
         `OP_WRITE:  return CMD_WRITE;
         default:    return CMD_NONE;
      endcase
   endfunction

   // ---------------- spi_clk domain: receive on rising edge
   logic [4:0]  rx_cnt_reg,   rx_cnt_next;
   logic [30:0] rx_shift_reg, rx_shift_next;
   logic [31:0] rx_word_reg,  rx_word_next;
   logic        rx_full_reg,  rx_full_next;

   always_comb begin
      rx_cnt_next   = rx_cnt_reg + 5'd1;
      rx_shift_next = {rx_shift_reg[29:0], mosi};
      rx_word_next  = rx_word_reg;
      rx_full_next  = rx_full_reg;
      if (rx_cnt_reg == 5'd31) begin
         rx_word_next = {rx_shift_reg, mosi};
         rx_full_next = 1'b1;
      end else if (rx_cnt_reg == 5'd0) begin
         rx_full_next = 1'b0;
      end
   end

   always_ff @(posedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         rx_cnt_reg   <= 5'd0;
         rx_shift_reg <= 31'h0;
      end else begin
         rx_cnt_reg   <= rx_cnt_next;
         rx_shift_reg <= rx_shift_next;
      end
   end

   // word and flag outlive the frame; ref side reads them only while cs_n is high
   always_ff @(posedge spi_clk) begin
      rx_word_reg <= rx_word_next;
      rx_full_reg <= rx_full_next;
   end

   // ---------------- spi_clk domain: transmit on falling edge
   logic [4:0]  tx_cnt_reg,   tx_cnt_next;
   logic [31:0] tx_shift_reg, tx_shift_next;
   logic        miso_reg,     miso_next;
   logic        miso_oe_reg;
   logic [31:0] resp_reg,     resp_next;

   always_comb begin
      tx_cnt_next = tx_cnt_reg + 5'd1;
      if (tx_cnt_reg == 5'd0) begin
         // resp_reg settled during the chip select gap
         tx_shift_next = {resp_reg[30:0], 1'b0};
         miso_next     = resp_reg[31];
      end else begin
         tx_shift_next = {tx_shift_reg[30:0], 1'b0};
         miso_next     = tx_shift_reg[31];
      end
   end

   always_ff @(negedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         tx_cnt_reg   <= 5'd0;
         tx_shift_reg <= 32'h0;
         miso_reg     <= 1'b0;
         miso_oe_reg  <= 1'b0;
      end else begin
         tx_cnt_reg   <= tx_cnt_next;
         tx_shift_reg <= tx_shift_next;
         miso_reg     <= miso_next;
         miso_oe_reg  <= 1'b1;
      end
   end

   assign miso    = miso_reg;
   assign miso_oe = miso_oe_reg;

   // ---------------- ref_clk domain: chip select synchroniser
   logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
   logic cs_fall, cs_rise;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end else begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   assign cs_fall = cs_s3_reg & ~cs_s2_reg;
   assign cs_rise = cs_s2_reg & ~cs_s3_reg;

   // ---------------- rate filter and saturation
   logic [15:0]          div_reg,  div_next;
   logic signed [FW-1:0] filt_reg, filt_next;
   logic [15:0]          rate_reg, rate_next;
   logic                 rate_upd;
   logic signed [FW-1:0] rate_ext;

   assign rate_ext = {{2{rate_in[RATE_IN_W-1]}}, rate_in};
   assign rate_upd = (div_reg == 16'(RATE_DIV - 1));

   always_comb begin
      div_next  = rate_upd ? 16'h0 : div_reg + 16'h1;
      filt_next = filt_reg;
      rate_next = rate_reg;
      if (rate_upd) begin
         // first order low pass; cutoff set by divider and shift
         filt_next = filt_reg + ((rate_ext - filt_reg) >>> FILT_SHIFT);
         rate_next = sat16(filt_reg);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_reg  <= 16'h0;
         filt_reg <= '0;
         rate_reg <= 16'h0;
      end else begin
         div_reg  <= div_next;
         filt_reg <= filt_next;
         rate_reg <= rate_next;
      end
   end

   // ---------------- fault test sequencing and fault flags
   ft_state_e   ft_state_reg, ft_state_next;
   logic [CNT_W-1:0] ft_cnt_reg, ft_cnt_next;
   logic        chk_reg,      chk_next;
   logic        post_chk_reg, post_chk_next;
   logic [15:0] fault_reg,    fault_next;
   logic        induce_reg,   induce_next;
   logic [15:0] fault_live;
   logic        induced;
   logic        fault_clr;
   logic        cmd_strobe;
   cmd_kind_e   kind;
   logic [7:0]  cmd_addr;

   assign induced = (ft_state_reg == FT_ACTIVE) || (ft_state_reg == FT_DECAY);

   always_comb begin
      fault_live        = 16'h0;
      fault_live[11:2]  = {fault_src[9:2],
                           fault_src[1] | fault_src[7] | fault_src[6],
                           fault_src[0] | fault_src[8]} | {10{induced}};
      fault_live[`FLT_CHK] = chk_reg;
   end

   always_comb begin
      chk_next = chk_reg;
      if (cmd_strobe && kind == CMD_SENSOR)
         chk_next = rx_word_reg[`CMD_CHK_BIT];
      ft_state_next = ft_state_reg;
      ft_cnt_next   = ft_cnt_reg + CNT_W'(1);
      unique case (ft_state_reg)
         FT_IDLE: begin
            ft_cnt_next = '0;
            if (chk_reg)
               ft_state_next = FT_GEN;
         end
         FT_GEN: begin
            if (!chk_reg) begin
               ft_state_next = FT_DECAY;
               ft_cnt_next   = '0;
            end else if (ft_cnt_reg == CNT_W'(GEN_CYC - 1)) begin
               ft_state_next = FT_ACTIVE;
            end
         end
         FT_ACTIVE: begin
            ft_cnt_next = '0;
            if (!chk_reg)
               ft_state_next = FT_DECAY;
         end
         FT_DECAY: begin
            if (chk_reg) begin
               ft_state_next = FT_GEN;
               ft_cnt_next   = '0;
            end else if (ft_cnt_reg == CNT_W'(DECAY_CYC - 1)) begin
               ft_state_next = FT_IDLE;
            end
         end
      endcase
      // a fault still present in the clearing cycle stays set
      fault_next    = (fault_clr ? 16'h0 : fault_reg) | fault_live;
      post_chk_next = (chk_reg & ~chk_next) |
                      (post_chk_reg & fault_next[`FLT_CST]);
      induce_next   = (ft_state_next == FT_GEN) || (ft_state_next == FT_ACTIVE);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ft_state_reg <= FT_IDLE;
         ft_cnt_reg   <= '0;
         chk_reg      <= 1'b0;
         post_chk_reg <= 1'b0;
         fault_reg    <= 16'h0;
         induce_reg   <= 1'b0;
      end else begin
         ft_state_reg <= ft_state_next;
         ft_cnt_reg   <= ft_cnt_next;
         chk_reg      <= chk_next;
         post_chk_reg <= post_chk_next;
         fault_reg    <= fault_next;
         induce_reg   <= induce_next;
      end
   end

   assign fault_induce = induce_reg;

   // ---------------- snapshot at select and command service
   logic [15:0] snap_rate_reg, snap_rate_next;
   logic [7:0]  snap_flt_reg,  snap_flt_next;
   logic [1:0]  snap_st_reg,   snap_st_next;
   logic [95:0] map_vec;

   assign map_vec = {rate_reg, temp_in, 6'h0, lo_st_in, hi_st_in,
                     quad_in, fault_reg};
   // ref side only looks at the rx word once cs_n has been seen high twice
   assign cmd_strobe = cs_rise & rx_full_reg;
   assign kind       = cmd_kind(rx_word_reg);
   assign cmd_addr   = rx_word_reg[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
   assign fault_clr  = cmd_strobe && (kind == CMD_SENSOR ||
                       (kind == CMD_READ && cmd_addr[7:1] == 7'(`ADDR_FAULT_HI >> 1)));

   always_comb begin
      snap_rate_next = snap_rate_reg;
      snap_flt_next  = snap_flt_reg;
      snap_st_next   = snap_st_reg;
      if (cs_fall) begin
         // state at select drives the next answer, so a test request shows one frame late
         snap_rate_next = rate_reg;
         snap_flt_next  = fault_reg[7:0];
         if (chk_reg)
            snap_st_next = `ST_SELFTEST;
         else if (fault_reg[`FLT_FAIL] || (post_chk_reg && fault_reg[`FLT_CST]))
            snap_st_next = `ST_ERROR;
         else
            snap_st_next = `ST_VALID;
      end
      resp_next = resp_reg;
      if (cmd_strobe) begin
         unique case (kind)
            CMD_SENSOR: resp_next = {snap_st_reg, snap_rate_reg,
                                     snap_flt_reg, 6'h0};
            CMD_READ:   resp_next = {`ST_VALID, reg_byte(cmd_addr, map_vec),
                                     reg_byte(cmd_addr + 8'h1, map_vec),
                                     14'h0};
            CMD_WRITE:  resp_next = {`ST_VALID,
                                     rx_word_reg[`CMD_WDATA_MSB:`CMD_WDATA_LSB],
                                     14'h0};
            CMD_NONE:   resp_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         snap_rate_reg <= 16'h0;
         snap_flt_reg  <= 8'h0;
         snap_st_reg   <= `ST_VALID;
         resp_reg      <= 32'h0;
      end else begin
         snap_rate_reg <= snap_rate_next;
         snap_flt_reg  <= snap_flt_next;
         snap_st_reg   <= snap_st_next;
         resp_reg      <= resp_next;
      end
   end

   // ---------------- assertions
   sequence s_sel_then_sensor;
      cs_fall ##[1:1000] (cmd_strobe && kind == CMD_SENSOR);
   endsequence

   property p_snap_rate;
      @(posedge ref_clk) disable iff (rst)
      cs_fall |=> snap_rate_reg == $past(rate_reg);
   endproperty
   a_snap_rate: assert property (p_snap_rate) else $error("rate not latched at select");

   property p_selftest_status;
      @(posedge ref_clk) disable iff (rst)
      (cs_fall && chk_reg) ##1 s_sel_then_sensor |=>
         resp_reg[31:30] == `ST_SELFTEST || $past(snap_st_reg) != `ST_SELFTEST;
   endproperty
   a_selftest_status: assert property (p_selftest_status) else $error("self-test status lost");

   property p_error_status;
      @(posedge ref_clk) disable iff (rst)
      cs_fall && !chk_reg && post_chk_reg && fault_reg[`FLT_CST] |=> snap_st_reg == `ST_ERROR;
   endproperty
   a_error_status: assert property (p_error_status) else $error("error status missing");

   property p_sensor_resp;
      @(posedge ref_clk) disable iff (rst)
      cmd_strobe && kind == CMD_SENSOR |=> resp_reg[29:14] == $past(snap_rate_reg);
   endproperty
   a_sensor_resp: assert property (p_sensor_resp) else $error("sensor answer wrong");

   property p_read_pair;
      @(posedge ref_clk) disable iff (rst)
      cmd_strobe && kind == CMD_READ && !cmd_addr[0] |=>
         resp_reg[29:22] == $past(reg_byte(cmd_addr, map_vec)) &&
         resp_reg[21:14] == $past(reg_byte(cmd_addr + 8'h1, map_vec));
   endproperty
   a_read_pair: assert property (p_read_pair) else $error("register pair wrong");

   property p_rate_sat;
      @(posedge ref_clk) disable iff (rst)
      rate_upd && filt_reg > $signed({{(FW-16){1'b0}}, `RATE_MAX}) |=> rate_reg == `RATE_MAX;
   endproperty
   a_rate_sat: assert property (p_rate_sat) else $error("rate not saturated");

   property p_fault_gen;
      @(posedge ref_clk) disable iff (rst)
      ft_state_reg == FT_GEN && chk_reg && ft_cnt_reg == CNT_W'(GEN_CYC - 1) |-> ##2 fault_reg[11:2] == 10'h3ff;
   endproperty
   a_fault_gen: assert property (p_fault_gen) else $error("faults not generated");

   property p_fault_decay;
      @(posedge ref_clk) disable iff (rst)
      ft_state_reg == FT_DECAY && !chk_reg && ft_cnt_reg == CNT_W'(DECAY_CYC - 1) |=>
         ft_state_reg == FT_IDLE && !induce_reg;
   endproperty
   a_fault_decay: assert property (p_fault_decay) else $error("decay did not end");

   property p_msb_first;
      @(negedge spi_clk) disable iff (cs_n)
      tx_cnt_reg != 5'd0 |=> miso_reg == $past(tx_shift_reg[31]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("bit order broken");

endmodule

// >>> testbench/spi_host_model.sv
// Purpose: host spi controller model, mode 3, 32-bit command/response exchanges
// Assumes: 32 ns link period, cs_n high at least 123 ns between frames
// Notes: link clock stands high outside frames; mosi is inverted once released
`timescale 1ns/1ps

module spi_host_model (
   output logic      spi_clk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   int oe_gaps;

   initial begin
      spi_clk = 1'b1;
      cs_n    = 1'b1;
      mosi    = 1'b0;
      oe_gaps = 0;
   end

   // odd start offset keeps link edges off the core clock's rising edges when the frame starts on one
   task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
      #3;
      cs_n = 1'b0;
      #16;
      for (int i = 31; i >= 0; i--) begin
         spi_clk = 1'b0;
         mosi    = cmd[i];
         #16;
         spi_clk = 1'b1;
         rsp[i]  = miso;
         if (miso_oe !== 1'b1) begin
            oe_gaps++;
         end
         #16;
      end
      cs_n = 1'b1;
      // released line must not look like a held command bit
      mosi = ~mosi;
      #120;
   endtask
endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench for the gyro spi readout block
// Assumes: filter bypassed and fault timers shortened by parameters
// Notes: every answer belongs to the command of the previous frame
`timescale 1ns/1ps
`include "gyro_params.svh"

module tb import gyro_pkg::*;;
   // arbitrary identity values
   localparam logic [15:0] part_id_val = 16'h1c3e;
   localparam logic [31:0] serial_val  = 32'h8421_7b5d;

   logic               ref_clk;
   logic               rst;
   logic               spi_clk;
   logic               cs_n;
   logic               mosi;
   logic signed [19:0] rate_in;
   logic        [9:0]  temp_in;
   logic        [15:0] lo_st_in;
   logic        [15:0] hi_st_in;
   logic        [15:0] quad_in;
   logic        [9:0]  fault_src;
   logic               miso;
   logic               miso_oe;
   logic               fault_induce;
   logic        [31:0] resp;
   int                 n_mismatch;
   int                 n_compared;

   gyro_spi_rate_register_readout #(
      .RATE_DIV   (2),
      .FILT_SHIFT (0),
      .GEN_CYC    (20),
      .DECAY_CYC  (20),
      .PART_ID    (part_id_val),
      .SERIAL_NUM (serial_val)
   ) dut_u (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .spi_clk      (spi_clk),
      .cs_n         (cs_n),
      .mosi         (mosi),
      .rate_in      (rate_in),
      .temp_in      (temp_in),
      .lo_st_in     (lo_st_in),
      .hi_st_in     (hi_st_in),
      .quad_in      (quad_in),
      .fault_src    (fault_src),
      .miso         (miso),
      .miso_oe      (miso_oe),
      .fault_induce (fault_induce)
   );

   spi_host_model host_u (
      .spi_clk (spi_clk),
      .cs_n    (cs_n),
      .mosi    (mosi),
      .miso    (miso),
      .miso_oe (miso_oe)
   );

   initial begin
      ref_clk = 1'b0;
   end
   always begin
      #5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic logic [31:0] read_cmd(input logic [7:0] addr);
      return {`OP_READ, 5'h0, addr, 16'h0, 1'b0};
   endfunction

   task automatic frame(input logic [31:0] cmd);
      host_u.xfer(cmd, resp);
      check({31'h0, miso_oe}, 32'h0);
   endtask

   task automatic sensor(input logic chk);
      frame({30'h0, chk, 1'b0});
   endtask

   task automatic status_is(input logic [1:0] st);
      check({30'h0, resp[31:30]}, {30'h0, st});
   endtask

   // start-up fault check; the first answer and the first answer after the decay wait are discarded
   task automatic run_fault_check;
      sensor(1'b1);
      sensor(1'b1);
      status_is(`ST_VALID);
      sensor(1'b1);
      status_is(`ST_SELFTEST);
      sensor(1'b1);
      check({22'h0, resp[31:30], resp[13:6]}, {22'h0, `ST_SELFTEST, 8'hfe});
      check({31'h0, fault_induce}, 32'h1);
      sensor(1'b0);
      status_is(`ST_SELFTEST);
      sensor(1'b0);
      status_is(`ST_SELFTEST);
      sensor(1'b0);
      status_is(`ST_ERROR);
      repeat (100) @(posedge ref_clk);
      check({31'h0, fault_induce}, 32'h0);
      sensor(1'b0);
      sensor(1'b0);
      check(resp, {`ST_VALID, 16'h0000, 8'h00, 6'h0});
   endtask

   task automatic run_rates;
      logic signed [19:0] rin  [7];
      logic        [15:0] rexp [7];
      rin  = '{20'sd24000, 20'sd0, -20'sd24000, 20'sd40000, -20'sd40000, 20'sd80, -20'sd80};
      rexp = '{16'h5dc0, 16'h0000, 16'ha240, 16'h7fff, 16'h8000, 16'h0050, 16'hffb0};
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         rate_in <= rin[i];
         repeat (10) @(posedge ref_clk);
         sensor(1'b0);
         sensor(1'b0);
         check(resp, {`ST_VALID, rexp[i], 8'h00, 6'h0});
      end
   endtask

   // reads issued back to back; the last frame only collects the final answer
   task automatic run_reg_reads;
      logic [15:0] want [9];
      @(posedge ref_clk);
      rate_in <= 20'sd24000;
      repeat (10) @(posedge ref_clk);
      want = '{16'h5dc0, {temp_in[9:2], temp_in[1:0], 6'h0}, lo_st_in, hi_st_in, quad_in,
               16'h0000, part_id_val, serial_val[31:16], serial_val[15:0]};
      for (int i = 0; i < 10; i++) begin
         frame(i < 9 ? read_cmd(8'(2 * i)) : 32'h0);
         if (i > 0) begin
            check(resp, {`ST_VALID, want[i-1], 14'h0});
         end
      end
   endtask

   task automatic run_fault_read;
      @(posedge ref_clk);
      fault_src <= 10'h001;
      repeat (10) @(posedge ref_clk);
      frame(read_cmd(`ADDR_FAULT_HI));
      // a write echoes its data; an unknown opcode answers zero
      frame({`OP_WRITE, 13'h0, 16'hbeef, 1'b0});
      check(resp, {`ST_VALID, 16'h0004, 14'h0});
      frame(32'hc000_0000);
      check(resp, {`ST_VALID, 16'hbeef, 14'h0});
      frame(32'h0);
      check(resp, 32'h0);
      check(32'(host_u.oe_gaps), 32'h0);
   endtask

   initial begin
      n_mismatch = 0;
      n_compared = 0;
      rst        = 1'b1;
      rate_in    = 20'sd0;
      temp_in    = 10'h2c5;
      lo_st_in   = 16'h1234;
      hi_st_in   = 16'hfedc;
      quad_in    = 16'h0a0b;
      fault_src  = 10'h000;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      run_fault_check;
      run_rates;
      run_reg_reads;
      run_fault_read;
      tally_and_finish;
   end

   // about 37 frames of 1.16 us each plus waits; a hang is cut well past that
   initial begin
      #150000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule
